// file: rtl/piec_pkg.sv
// Shared constants for the interrupt, expanded control and strap register slice.
// Assumes a management serial frame with a 32-bit preamble and 5-bit addresses.
package piec_pkg;

   // Register addresses on the management interface.
   localparam logic [4:0] REG_STRAP = 5'h17;
   localparam logic [4:0] REG_XCTL = 5'h18;
   localparam logic [4:0] REG_EVT = 5'h1B;

   // Reset values of the writable registers.
   localparam logic [15:0] XCTL_RST = 16'h0801;
   localparam logic [7:0] EVT_EN_RST = 8'h00;
   localparam logic [7:0] EVT_FLAG_RST = 8'h00;
   localparam logic [15:0] RD_NONE = 16'h0000;

   // Field positions.
   localparam int EVT_EN_LSB = 8;
   localparam int EVT_FLAG_LSB = 0;
   localparam int EVT_NUM = 8;
   localparam int XCTL_ENERGY_OFF_BIT = 11;
   localparam int XCTL_RXLAT_BIT = 10;
   localparam int XCTL_PRE10_BIT = 6;
   localparam int STRAP_PHYAD_LSB = 13;
   localparam int STRAP_FILTER_BIT = 8;
   localparam int STRAP_RELAY_BIT = 7;
   localparam int STRAP_NAND_BIT = 5;
   localparam int STRAP_MII_BIT = 0;

   // Flag positions of the event sources.
   localparam int FLG_JABBER = 7;
   localparam int FLG_RX_ERROR = 6;
   localparam int FLG_PAGE_RX = 5;
   localparam int FLG_PD_FAULT = 4;
   localparam int FLG_LP_ACK = 3;
   localparam int FLG_LINK_DOWN = 2;
   localparam int FLG_REMOTE_FAULT = 1;
   localparam int FLG_LINK_UP = 0;

   // Management frame layout.
   localparam int PREAMBLE_LEN = 32;
   localparam logic [1:0] OP_READ = 2'b10;
   localparam logic [1:0] OP_WRITE = 2'b01;
   localparam logic [4:0] HDR_LAST = 5'h0C;
   localparam logic [4:0] TA_LAST = 5'h01;
   localparam logic [4:0] DATA_LAST = 5'h0F;
   localparam logic [4:0] DATA_END = 5'h10;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [4:0] CNT_ONE = 5'h01;

   typedef enum logic [2:0] {
      S_PRE = 3'b000,
      S_HDR = 3'b001,
      S_TA = 3'b010,
      S_RD = 3'b011,
      S_WR = 3'b100
   } piec_ser_e;

endpackage : piec_pkg

// file: rtl/piec_mgmt_serial.sv
// Management serial slave: decodes read and write frames into register strobes.
// Assumes mdc and mdio_i are already synchronous to core_clk and mdc is much slower.
`timescale 1ns/1ns
`default_nettype none
module piec_mgmt_serial import piec_pkg::*; #(
   parameter int unsigned PRE_ONES = PREAMBLE_LEN
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic resetn,
   // Serial pins.
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   // Own address.
   input wire logic [4:0] phy_addr,
   // Register side.
   output logic [4:0] reg_addr,
   output logic rd_stb,
   input wire logic [15:0] rd_data,
   output logic wr_stb,
   output logic [15:0] wr_data
);

   if (PRE_ONES < 1 || PRE_ONES > 63) begin : g_bad_pre
      $error("PRE_ONES must lie between 1 and 63");
   end

   localparam logic [5:0] PRE_CNT = PRE_ONES[5:0];

   piec_ser_e state_q, state_d;
   logic mdc_q;
   logic [5:0] ones_q, ones_d;
   logic [4:0] cnt_q, cnt_d;
   logic [11:0] hdr_q, hdr_d;
   logic is_rd_q, is_rd_d;
   logic [15:0] sh_q, sh_d;
   logic [4:0] addr_q, addr_d;
   logic wr_stb_q, wr_stb_d;
   logic [15:0] wr_data_q, wr_data_d;
   logic o_q, o_d, oe_q, oe_d;

   wire rise = mdc & ~mdc_q;
   wire [12:0] hdr_full = {hdr_q, mdio_i};
   wire op_rd = hdr_full[11:10] == OP_READ;
   wire op_wr = hdr_full[11:10] == OP_WRITE;
   wire hdr_ok = hdr_full[12] & (hdr_full[9:5] == phy_addr) & (op_rd | op_wr);

   // The read strobe is combinational so the flags clear in the very cycle they are sampled.
   assign rd_stb = rise & (state_q == S_TA) & is_rd_q;
   assign reg_addr = addr_q;
   assign wr_stb = wr_stb_q;
   assign wr_data = wr_data_q;
   assign mdio_o = o_q;
   assign mdio_oe = oe_q;

   always_comb begin
      state_d = state_q;
      ones_d = ones_q;
      cnt_d = cnt_q;
      hdr_d = hdr_q;
      is_rd_d = is_rd_q;
      sh_d = sh_q;
      addr_d = addr_q;
      wr_stb_d = 1'b0;
      wr_data_d = wr_data_q;
      o_d = o_q;
      oe_d = oe_q;
      if (rise) begin
         case (state_q)
            S_PRE: begin
               if (mdio_i) begin
                  if (ones_q < PRE_CNT) ones_d = ones_q + 6'h01;
               end else begin
                  if (ones_q == PRE_CNT) begin
                     state_d = S_HDR;
                     cnt_d = CNT_ZERO;
                  end
                  ones_d = 6'h00;
               end
            end
            S_HDR: begin
               hdr_d = hdr_full[11:0];
               cnt_d = cnt_q + CNT_ONE;
               if (cnt_q == HDR_LAST) begin
                  // Frames for another address or with a bad start are ignored.
                  state_d = hdr_ok ? S_TA : S_PRE;
                  is_rd_d = op_rd;
                  addr_d = hdr_full[4:0];
                  cnt_d = CNT_ZERO;
               end
            end
            S_TA: begin
               if (is_rd_q) begin
                  sh_d = rd_data;
                  o_d = 1'b0;
                  oe_d = 1'b1;
                  state_d = S_RD;
                  cnt_d = CNT_ZERO;
               end else begin
                  cnt_d = cnt_q + CNT_ONE;
                  if (cnt_q == TA_LAST) begin
                     state_d = S_WR;
                     cnt_d = CNT_ZERO;
                  end
               end
            end
            S_RD: begin
               cnt_d = cnt_q + CNT_ONE;
               if (cnt_q == DATA_END) begin
                  o_d = 1'b0;
                  oe_d = 1'b0;
                  state_d = S_PRE;
               end else begin
                  o_d = sh_q[15];
                  sh_d = {sh_q[14:0], 1'b0};
               end
            end
            S_WR: begin
               sh_d = {sh_q[14:0], mdio_i};
               cnt_d = cnt_q + CNT_ONE;
               if (cnt_q == DATA_LAST) begin
                  wr_stb_d = 1'b1;
                  wr_data_d = {sh_q[14:0], mdio_i};
                  state_d = S_PRE;
               end
            end
            default: state_d = S_PRE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= S_PRE;
         mdc_q <= 1'b0;
         ones_q <= 6'h00;
         cnt_q <= CNT_ZERO;
         hdr_q <= 12'h000;
         is_rd_q <= 1'b0;
         sh_q <= 16'h0000;
         addr_q <= 5'h00;
         wr_stb_q <= 1'b0;
         wr_data_q <= 16'h0000;
         o_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         mdc_q <= mdc;
         ones_q <= ones_d;
         cnt_q <= cnt_d;
         hdr_q <= hdr_d;
         is_rd_q <= is_rd_d;
         sh_q <= sh_d;
         addr_q <= addr_d;
         wr_stb_q <= wr_stb_d;
         wr_data_q <= wr_data_d;
         o_q <= o_d;
         oe_q <= oe_d;
      end
   end

endmodule : piec_mgmt_serial
`default_nettype wire

// file: rtl/piec_regs.sv
// Interrupt enable and event flags, expanded control and strap status registers.
// Assumes event inputs are one-cycle or level pulses synchronous to core_clk.
//
// Notes on behaviour
// RULE_01: Eight event enables in bits 15 to 8, writable, all reset to zero.
// RULE_02: Jabber flag in bit 7, read-only, clears on read, resets to zero.
// RULE_03: Receive error flag in bit 6, read-only, clears on read, resets zero.
// RULE_04: Page received flag in bit 5, read-only, clears on read, resets zero.
// RULE_05: Parallel detect fault flag in bit 4, read-only, clears on read.
// RULE_06: Partner acknowledge flag in bit 3, read-only, clears on read.
// RULE_07: Link down flag in bit 2, read-only, clears on read, resets zero.
// RULE_08: Remote fault flag in bit 1, read-only, clears on read, resets zero.
// RULE_09: Link up flag in bit 0, read-only, clears on read, resets zero.
// RULE_10: Control bit 11 set disables energy detect power down; resets to one.
// RULE_11: Control bit 10 set gives variable receive latency; resets to zero.
// RULE_12: Software sets control bit 6 when in back-to-back relay mode at 10 Mb/s.
// RULE_13: Strap status bit 0 reads one when normal interface mode was strapped.
// RULE_14: Strap status bit 7 reads one when back-to-back relay mode was strapped.
// RULE_15: Interrupt output is high while any enabled event flag is set.
// RULE_16: Writes to flag bits are ignored; reserved writable bits keep reset values. Here a control write loads all 16 bits of the written word.
`timescale 1ns/1ns
`default_nettype none
module piec_regs import piec_pkg::*; (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic resetn,
   // Management serial pins.
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   // Straps, caught once after reset release.
   input wire logic [2:0] strap_phy_addr,
   input wire logic strap_filter_off,
   input wire logic strap_back_to_back_relay_mode,
   input wire logic strap_nand_tree,
   input wire logic strap_mii_normal,
   // Event sources.
   input wire logic evt_jabber,
   input wire logic evt_rx_error,
   input wire logic evt_page_rx,
   input wire logic evt_pd_fault,
   input wire logic evt_lp_ack,
   input wire logic evt_link_down,
   input wire logic evt_remote_fault,
   input wire logic evt_link_up,
   // Outputs to the transceiver.
   output logic event_irq,
   output logic energy_detect_power_down_off,
   output logic rx_latency_variable,
   output logic preamble_10bt_enable
);

   function automatic logic reg_hit(input logic [4:0] a, input logic [4:0] r);
      reg_hit = (a == r);
   endfunction : reg_hit

   logic [4:0] reg_addr;
   logic rd_stb, wr_stb;
   logic [15:0] wr_data, rd_data, strap_word;
   logic [7:0] evt_en_q, evt_en_d, evt_flags_q, evt_flags_d;
   logic [15:0] xctl_q, xctl_d;
   logic strap_valid_q;
   logic [2:0] strap_phy_q;
   logic strap_filt_q, strap_relay_q, strap_nand_q, strap_mii_q;

   piec_mgmt_serial #(.PRE_ONES(PREAMBLE_LEN)) u_serial (
      .core_clk(core_clk),
      .resetn(resetn),
      .mdc(mdc),
      .mdio_i(mdio_i),
      .mdio_o(mdio_o),
      .mdio_oe(mdio_oe),
      .phy_addr({2'b00, strap_phy_q}),
      .reg_addr(reg_addr),
      .rd_stb(rd_stb),
      .rd_data(rd_data),
      .wr_stb(wr_stb),
      .wr_data(wr_data)
   );

   wire [7:0] evt_vec = {evt_jabber, evt_rx_error, evt_page_rx, evt_pd_fault,
                         evt_lp_ack, evt_link_down, evt_remote_fault, evt_link_up};
   wire evt_rd = rd_stb & reg_hit(reg_addr, REG_EVT);
   wire evt_wr = wr_stb & reg_hit(reg_addr, REG_EVT);
   wire xctl_wr = wr_stb & reg_hit(reg_addr, REG_XCTL);

   // A new event in the reading cycle survives, since it was not in the word returned.
   assign evt_flags_d = (evt_rd ? EVT_FLAG_RST : evt_flags_q) | evt_vec; // RULE_02 RULE_03 RULE_04 RULE_05 RULE_06 RULE_07 RULE_08 RULE_09
   assign evt_en_d = evt_wr ? wr_data[EVT_EN_LSB +: EVT_NUM] : evt_en_q; // RULE_01 RULE_16
   assign xctl_d = xctl_wr ? wr_data : xctl_q; // RULE_16

   assign event_irq = |(evt_flags_q & evt_en_q); // RULE_15
   assign energy_detect_power_down_off = xctl_q[XCTL_ENERGY_OFF_BIT]; // RULE_10
   assign rx_latency_variable = xctl_q[XCTL_RXLAT_BIT]; // RULE_11
   assign preamble_10bt_enable = xctl_q[XCTL_PRE10_BIT]; // RULE_12

   always_comb begin
      strap_word = RD_NONE;
      strap_word[STRAP_PHYAD_LSB +: 3] = strap_phy_q;
      strap_word[STRAP_FILTER_BIT] = strap_filt_q;
      strap_word[STRAP_RELAY_BIT] = strap_relay_q; // RULE_14
      strap_word[STRAP_NAND_BIT] = strap_nand_q;
      strap_word[STRAP_MII_BIT] = strap_mii_q; // RULE_13
   end

   // Registers outside this slice read as zero and ignore writes.
   assign rd_data = reg_hit(reg_addr, REG_EVT) ? {evt_en_q, evt_flags_q} :
                    reg_hit(reg_addr, REG_XCTL) ? xctl_q :
                    reg_hit(reg_addr, REG_STRAP) ? strap_word : RD_NONE;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         evt_en_q <= EVT_EN_RST;
         evt_flags_q <= EVT_FLAG_RST;
         xctl_q <= XCTL_RST;
      end else begin
         evt_en_q <= evt_en_d;
         evt_flags_q <= evt_flags_d;
         xctl_q <= xctl_d;
      end
   end

   // Straps are sampled on the first edge after release, never by the reset itself.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         strap_valid_q <= 1'b0;
         strap_phy_q <= 3'h0;
         strap_filt_q <= 1'b0;
         strap_relay_q <= 1'b0;
         strap_nand_q <= 1'b0;
         strap_mii_q <= 1'b0;
      end else if (!strap_valid_q) begin
         strap_valid_q <= 1'b1;
         strap_phy_q <= strap_phy_addr;
         strap_filt_q <= strap_filter_off;
         strap_relay_q <= strap_back_to_back_relay_mode;
         strap_nand_q <= strap_nand_tree;
         strap_mii_q <= strap_mii_normal;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_evt_read;
      evt_rd;
   endsequence

   sequence s_quiet;
      evt_vec == EVT_FLAG_RST;
   endsequence

   a_flag_set_wins: assert property ((evt_vec != EVT_FLAG_RST) |=> // RULE_02
      ((evt_flags_q & $past(evt_vec)) == $past(evt_vec)))
      else $error("event flag not set by its source");
   a_flag_read_clr: assert property (s_evt_read |=> (evt_flags_q == $past(evt_vec))) // RULE_09
      else $error("event flags not cleared by a read");
   a_flag_hold: assert property ((!evt_rd && (evt_vec == EVT_FLAG_RST)) |=> // RULE_05
      (evt_flags_q == $past(evt_flags_q)))
      else $error("event flags changed without cause");
   a_flag_wr_ignored: assert property ((evt_wr && !evt_rd) |=> // RULE_16
      (evt_flags_q == ($past(evt_flags_q) | $past(evt_vec))))
      else $error("write disturbed read-only flags");
   a_enable_write: assert property (evt_wr |=> // RULE_01
      (evt_en_q == $past(wr_data[EVT_EN_LSB +: EVT_NUM])))
      else $error("enable bits not written");
   a_irq_follow: assert property (((evt_vec & evt_en_q) != EVT_FLAG_RST && !evt_wr) |=> // RULE_15
      event_irq)
      else $error("interrupt missing for enabled event");
   a_irq_release: assert property ((s_evt_read ##0 s_quiet) ##1 (!evt_wr) |-> // RULE_15
      !event_irq)
      else $error("interrupt held after flags cleared");
   a_xctl_write: assert property (xctl_wr |=> (xctl_q == $past(wr_data)) && // RULE_10
      (rx_latency_variable == $past(wr_data[XCTL_RXLAT_BIT])))
      else $error("expanded control not written");
   a_xctl_hold: assert property (!xctl_wr |=> (xctl_q == $past(xctl_q))) // RULE_11
      else $error("expanded control changed without write");
   a_strap_hold: assert property (strap_valid_q |=> // RULE_13
      (strap_mii_q == $past(strap_mii_q)) && (strap_relay_q == $past(strap_relay_q)))
      else $error("strap status changed after capture");

   // Straps are judged one edge after capture, against the pin levels seen at the capture edge.
   a_strap_capture: assert property (!strap_valid_q |=> // RULE_13
      strap_valid_q && (strap_mii_q == $past(strap_mii_normal)))
      else $error("normal interface strap not captured");
   a_strap_relay: assert property (!strap_valid_q |=> // RULE_14
      (strap_relay_q == $past(strap_back_to_back_relay_mode)))
      else $error("relay strap not captured");

   // A flag may only rise in the cycle after its own source was high.
   a_flag_no_spurious: assert property (1'b1 |=> // RULE_03
      ((evt_flags_q & ~$past(evt_flags_q) & ~$past(evt_vec)) == EVT_FLAG_RST))
      else $error("event flag set without its source");
   a_enable_hold: assert property (!evt_wr |=> (evt_en_q == $past(evt_en_q))) // RULE_01
      else $error("enable bits changed without write");
   a_irq_masked: assert property ((!evt_wr && // RULE_15
      (((evt_flags_q | evt_vec) & evt_en_q) == EVT_FLAG_RST)) |=> !event_irq)
      else $error("interrupt raised by a disabled source");
   a_xctl_pins: assert property (xctl_wr |=> // RULE_10
      (energy_detect_power_down_off == $past(wr_data[XCTL_ENERGY_OFF_BIT])) &&
      (preamble_10bt_enable == $past(wr_data[XCTL_PRE10_BIT])))
      else $error("expanded control outputs not updated");

   // Each source must reach its own flag bit; a swapped pin would slip past the bulk checks.
   a_jabber_flag: assert property (evt_jabber |=> evt_flags_q[FLG_JABBER]) // RULE_02
      else $error("jabber flag not set");
   a_rxerr_flag: assert property (evt_rx_error |=> evt_flags_q[FLG_RX_ERROR]) // RULE_03
      else $error("receive error flag not set");
   a_page_flag: assert property (evt_page_rx |=> evt_flags_q[FLG_PAGE_RX]) // RULE_04
      else $error("page received flag not set");
   a_pdfault_flag: assert property (evt_pd_fault |=> evt_flags_q[FLG_PD_FAULT]) // RULE_05
      else $error("parallel detect fault flag not set");
   a_ack_flag: assert property (evt_lp_ack |=> evt_flags_q[FLG_LP_ACK]) // RULE_06
      else $error("partner acknowledge flag not set");
   a_down_flag: assert property (evt_link_down |=> evt_flags_q[FLG_LINK_DOWN]) // RULE_07
      else $error("link down flag not set");
   a_rfault_flag: assert property (evt_remote_fault |=> evt_flags_q[FLG_REMOTE_FAULT]) // RULE_08
      else $error("remote fault flag not set");
   a_up_flag: assert property (evt_link_up |=> evt_flags_q[FLG_LINK_UP]) // RULE_09
      else $error("link up flag not set");

endmodule : piec_regs
`default_nettype wire

// file: test/piec_mgmt_host.sv
// Station management controller model that issues framed register reads and writes.
// Assumes the bench resolves the shared data wire and feeds the wire level back on mdio.
`timescale 1ns/1ns
`default_nettype none
module piec_mgmt_host import piec_pkg::*; #(
   parameter logic [4:0] PHY_ADDR = 5'h05
) (
   // Clock.
   input wire logic core_clk,
   // Serial pins.
   input wire logic mdio,
   output logic mdc,
   output logic host_d,
   output logic host_oe
);
   initial begin
      mdc = 1'b0;
      host_d = 1'b1;
      host_oe = 1'b0;
   end

   // The serial clock is low for two core cycles and high for three, never under the minimum.
   // The serial clock stands low between frames.
   task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
         output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hFFFF_FFFF, 2'b01, op, PHY_ADDR, ra, 2'b10, wd};
      rd = 16'h0000;
      for (int i = 0; i < 64; i++) begin
         @(posedge core_clk);
         mdc <= 1'b0;
         host_oe <= !(op == OP_READ && i >= 46);
         host_d <= f[63 - i];
         repeat (2) @(posedge core_clk);
         if (i >= 48) rd[63 - i] = mdio;
         mdc <= 1'b1;
         repeat (2) @(posedge core_clk);
      end
      @(posedge core_clk);
      mdc <= 1'b0;
      host_oe <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask : xfer
endmodule : piec_mgmt_host
`default_nettype wire

// file: test/test_phy_interrupt_and_expanded_control.sv
// Self-checking bench for the event, expanded control and strap status registers.
// Assumes the host model above and a pull-up on the management data wire.
`timescale 1ns/1ns
`default_nettype none
module test_phy_interrupt_and_expanded_control import piec_pkg::*;;
   localparam logic [2:0] STRAP_ADDR = 3'h5;
   localparam logic [15:0] STRAP_EXP = 16'hA181;
   // Second strap set: only the test tree pin high, address kept so the host still matches.
   localparam logic [15:0] STRAP_EXP_ALT = 16'hA020;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] ev = 8'h00;
   logic [3:0] straps = 4'hD;
   int errors = 0;
   int compares = 0;
   wire mdc, mdio_o, mdio_oe, host_d, host_oe, event_irq, power_down_off, rx_lat, pre10;
   // Nobody driving leaves the pull-up in charge, so a released wire reads one.
   wire mdio = mdio_oe ? mdio_o : (host_oe ? host_d : 1'b1);

   always #10 core_clk = ~core_clk;

   piec_regs uut (.core_clk(core_clk), .resetn(resetn), .mdc(mdc), .mdio_i(mdio),
      .mdio_o(mdio_o), .mdio_oe(mdio_oe), .strap_phy_addr(STRAP_ADDR),
      .strap_filter_off(straps[3]), .strap_back_to_back_relay_mode(straps[2]),
      .strap_nand_tree(straps[1]), .strap_mii_normal(straps[0]), .evt_jabber(ev[7]),
      .evt_rx_error(ev[6]), .evt_page_rx(ev[5]), .evt_pd_fault(ev[4]), .evt_lp_ack(ev[3]),
      .evt_link_down(ev[2]), .evt_remote_fault(ev[1]), .evt_link_up(ev[0]),
      .event_irq(event_irq), .energy_detect_power_down_off(power_down_off),
      .rx_latency_variable(rx_lat), .preamble_10bt_enable(pre10));

   piec_mgmt_host #(.PHY_ADDR({2'b00, STRAP_ADDR})) host (.core_clk(core_clk), .mdio(mdio),
      .mdc(mdc), .host_d(host_d), .host_oe(host_oe));

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
      host.xfer(OP_READ, a, 16'h0000, d);
   endtask : rd_reg

   task automatic wr_reg(input logic [4:0] a, input logic [15:0] wd);
      logic [15:0] unused;
      host.xfer(OP_WRITE, a, wd, unused);
   endtask : wr_reg

   task automatic pulse(input int k);
      @(posedge core_clk);
      ev <= 8'h01 << k;
      @(posedge core_clk);
      ev <= 8'h00;
      @(negedge core_clk);
   endtask : pulse

   task automatic end_sim;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   task automatic t_reset;
      logic [15:0] d;
      @(negedge core_clk);
      chk_bit(mdio_oe, 1'b0);
      chk_bit(power_down_off, 1'b1);
      chk_bit(rx_lat, 1'b0);
      chk_bit(pre10, 1'b0);
      chk_bit(event_irq, 1'b0);
      rd_reg(REG_STRAP, d);
      chk_word(d, STRAP_EXP);
      rd_reg(REG_XCTL, d);
      chk_word(d, XCTL_RST);
      rd_reg(REG_EVT, d);
      chk_word(d, 16'h0000);
      $display("test reset values done");
   endtask : t_reset

   task automatic t_xctl;
      logic [15:0] d;
      wr_reg(REG_XCTL, 16'h0440);
      @(negedge core_clk);
      chk_bit(power_down_off, 1'b0);
      chk_bit(rx_lat, 1'b1);
      chk_bit(pre10, 1'b1);
      rd_reg(REG_XCTL, d);
      chk_word(d, 16'h0440);
      wr_reg(REG_STRAP, 16'h0000);
      rd_reg(REG_STRAP, d);
      chk_word(d, STRAP_EXP);
      rd_reg(5'h1C, d);
      chk_word(d, RD_NONE);
      $display("test expanded control done");
   endtask : t_xctl

   // Each source in turn: a disabled neighbour must stay silent, then the enabled one fires.
   task automatic t_events;
      logic [15:0] d;
      int j;
      for (int i = 0; i < 8; i++) begin
         j = (i + 1) % 8;
         wr_reg(REG_EVT, 16'h00FF | (16'h0100 << i));
         pulse(j);
         chk_bit(event_irq, 1'b0);
         pulse(i);
         chk_bit(event_irq, 1'b1);
         rd_reg(REG_EVT, d);
         chk_word(d, (16'h0100 << i) | (16'h0001 << i) | (16'h0001 << j));
         @(negedge core_clk);
         chk_bit(event_irq, 1'b0);
         rd_reg(REG_EVT, d);
         chk_word(d, 16'h0100 << i);
      end
      $display("test event flags done");
   endtask : t_events

   // A second reset with other straps: capture must follow the pins and control must reload.
   task automatic t_strap;
      logic [15:0] d;
      @(posedge core_clk);
      resetn <= 1'b0;
      straps <= 4'h2;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      @(negedge core_clk);
      chk_bit(mdio_oe, 1'b0);
      chk_bit(power_down_off, 1'b1);
      chk_bit(rx_lat, 1'b0);
      chk_bit(pre10, 1'b0);
      chk_bit(event_irq, 1'b0);
      repeat (2) @(posedge core_clk);
      rd_reg(REG_STRAP, d);
      chk_word(d, STRAP_EXP_ALT);
      rd_reg(REG_XCTL, d);
      chk_word(d, XCTL_RST);
      rd_reg(REG_EVT, d);
      chk_word(d, 16'h0000);
      $display("test strap recapture done");
   endtask : t_strap

   initial begin
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_reset();
      t_xctl();
      t_events();
      t_strap();
      end_sim();
   end

   initial begin
      repeat (100000) @(posedge core_clk);
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_sim();
   end
endmodule : test_phy_interrupt_and_expanded_control
`default_nettype wire
